// *** design/motor_overcurrent_stall_stages.sv ***
`timescale 1ns/1ns
`default_nettype none
module motor_overcurrent_stall_stages #(
	parameter int unsigned CW = motor_prot_pkg::CUR_W,
	parameter int unsigned TW = motor_prot_pkg::TIME_W
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic [5:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	output logic [31:0]        avs_readdata,
	output logic               avs_waitrequest,
	input  wire logic          measTick,
	input  wire logic [CW-1:0] phaseCurrentA,
	input  wire logic [CW-1:0] phaseCurrentB,
	input  wire logic [CW-1:0] phaseCurrentC,
	input  wire logic [CW-1:0] neutralCurrent,
	input  wire logic          btnStep,
	input  wire logic          btnProgram,
	input  wire logic          btnReset,
	input  wire logic          extResetIn,
	input  wire logic          speedSwitchIn,
	output logic               signalOutOne,
	output logic               signalOutTwo,
	output logic               signalOutThree,
	output logic               earthFaultTripOut,
	output logic               stallIndicator,
	output logic               highsetIndicator,
	output logic               earthFaultIndicator,
	output logic [3:0]         displayCode,
	output logic               eraseRecords,
	output logic [6:0]         thermalInitLevel
);
	if (CW != 16 || TW != 16) begin : gWidthCheck
		$error("motor stages: CW and TW must be 16");
	end

	logic [motor_prot_pkg::SW_W-1:0] switches;
	logic [15:0] flcSet, stallCur, stallTime, hsCur, hsTime, efCur, efTime;
	logic        ack, wrEn, remoteKeep, remoteErase, initDone;
	logic [15:0] maxCurrent, efCurrent;
	logic        stallStart, stallRaw, stallLatch, stallTrip, dtExpired;
	logic        hsStart, hsRaw, hsLatch, hsTrip;
	logic        efStart, efRaw, efTripPrev;
	logic [47:0] stressAcc, stressLimit;
	logic [31:0] currentSq;
	logic [48:0] stressSum;
	logic        stressActive, stressOver, resetLatch, resetErase, stallPrev;
	logic [17:0] hsThreshold;
	logic [31:0] lowThr, highThr, endThr, curScaled;
	logic [3:0]  winCount;
	motor_prot_pkg::start_state_t startState;
	logic        startingSituation;

	function automatic logic [15:0] clampSet(input logic [31:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		if (v < {16'h0000, lo}) return lo;
		if (v > {16'h0000, hi}) return hi;
		return v[15:0];
	endfunction

	// Bus slave: one wait state on every access, write lands at the release edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign wrEn = avs_write && ack;

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			ack <= 1'b0;
		else
			ack <= (avs_read || avs_write) && !ack;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			switches  <= motor_prot_pkg::SWITCH_RESET;
			flcSet    <= motor_prot_pkg::FLC_RESET;
			stallCur  <= motor_prot_pkg::STALL_CUR_MIN;
			stallTime <= motor_prot_pkg::STALL_TIM_MIN;
			hsCur     <= motor_prot_pkg::HS_CUR_MIN;
			hsTime    <= motor_prot_pkg::HS_TIM_MIN;
			efCur     <= motor_prot_pkg::EF_CUR_MIN;
			efTime    <= motor_prot_pkg::EF_TIM_MIN;
		end else if (wrEn) begin
			case (avs_address)
				motor_prot_pkg::OFS_SWITCH: switches <= avs_writedata[motor_prot_pkg::SW_W-1:0];
				motor_prot_pkg::OFS_FLC:    flcSet <= avs_writedata[15:0];
				// Out-of-range settings are pulled to the nearest limit
				motor_prot_pkg::OFS_STCUR: stallCur <= clampSet(avs_writedata,
					motor_prot_pkg::STALL_CUR_MIN, motor_prot_pkg::STALL_CUR_MAX);
				motor_prot_pkg::OFS_STTIM: stallTime <= clampSet(avs_writedata,
					motor_prot_pkg::STALL_TIM_MIN, motor_prot_pkg::STALL_TIM_MAX);
				motor_prot_pkg::OFS_HSCUR: hsCur <= clampSet(avs_writedata,
					motor_prot_pkg::HS_CUR_MIN, motor_prot_pkg::HS_CUR_MAX);
				motor_prot_pkg::OFS_HSTIM: hsTime <= clampSet(avs_writedata,
					motor_prot_pkg::HS_TIM_MIN, motor_prot_pkg::HS_TIM_MAX);
				motor_prot_pkg::OFS_EFCUR: efCur <= clampSet(avs_writedata,
					motor_prot_pkg::EF_CUR_MIN, motor_prot_pkg::EF_CUR_MAX);
				motor_prot_pkg::OFS_EFTIM: efTime <= clampSet(avs_writedata,
					motor_prot_pkg::EF_TIM_MIN, motor_prot_pkg::EF_TIM_MAX);
				default: ;
			endcase
		end
	end

	assign remoteKeep  = wrEn && avs_address == motor_prot_pkg::OFS_REMOTE
		&& avs_writedata[motor_prot_pkg::RC_KEEP];
	assign remoteErase = wrEn && avs_address == motor_prot_pkg::OFS_REMOTE
		&& avs_writedata[motor_prot_pkg::RC_ERASE];

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack) begin
			case (avs_address)
				motor_prot_pkg::OFS_SWITCH: avs_readdata <= {19'h00000, switches};
				motor_prot_pkg::OFS_FLC:   avs_readdata <= {16'h0000, flcSet};
				motor_prot_pkg::OFS_STCUR: avs_readdata <= {16'h0000, stallCur};
				motor_prot_pkg::OFS_STTIM: avs_readdata <= {16'h0000, stallTime};
				// Disabled stage reads as infinite setting
				motor_prot_pkg::OFS_HSCUR: avs_readdata <= {16'h0000,
					switches[motor_prot_pkg::SW_HS_DISABLE] ? 16'hffff : hsCur};
				motor_prot_pkg::OFS_HSTIM: avs_readdata <= {16'h0000, hsTime};
				motor_prot_pkg::OFS_EFCUR: avs_readdata <= {16'h0000, efCur};
				motor_prot_pkg::OFS_EFTIM: avs_readdata <= {16'h0000, efTime};
				motor_prot_pkg::OFS_STATUS: avs_readdata <= {9'h000, thermalInitLevel,
					displayCode, 2'b00, earthFaultIndicator, highsetIndicator,
					stallIndicator, startingSituation, efRaw, efStart, hsTrip, hsStart,
					stallTrip, stallStart};
				motor_prot_pkg::OFS_MAXCUR: avs_readdata <= {16'h0000, maxCurrent};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Button strap is caught on the first edge after reset release
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			initDone         <= 1'b0;
			thermalInitLevel <= motor_prot_pkg::THERM_WARM;
		end else if (!initDone) begin
			initDone         <= 1'b1;
			thermalInitLevel <= (btnStep && btnProgram) ? motor_prot_pkg::THERM_COLD
				: motor_prot_pkg::THERM_WARM;
		end
	end

	// Highest phase and neutral magnitude, refreshed once per tick
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			maxCurrent <= 16'h0000;
			efCurrent  <= 16'h0000;
		end else if (measTick) begin
			if (phaseCurrentA >= phaseCurrentB && phaseCurrentA >= phaseCurrentC)
				maxCurrent <= phaseCurrentA;
			else if (phaseCurrentB >= phaseCurrentC)
				maxCurrent <= phaseCurrentB;
			else
				maxCurrent <= phaseCurrentC;
			efCurrent <= neutralCurrent;
		end
	end

	// Starting situation detector, thresholds scaled from full-load current
	assign curScaled = {16'h0000, maxCurrent} * 32'd100;
	assign lowThr  = {16'h0000, flcSet} * motor_prot_pkg::START_LOW_PCT;
	assign highThr = {16'h0000, flcSet} * motor_prot_pkg::START_HIGH_PCT;
	assign endThr  = {16'h0000, flcSet} * motor_prot_pkg::START_END_PCT;
	assign startingSituation = startState == motor_prot_pkg::START_ACTIVE;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			startState <= motor_prot_pkg::START_IDLE;
			winCount   <= 4'h0;
		end else if (measTick) begin
			case (startState)
				motor_prot_pkg::START_IDLE: begin
					if (curScaled < lowThr)
						startState <= motor_prot_pkg::START_STANDSTILL;
				end
				motor_prot_pkg::START_STANDSTILL: begin
					winCount <= 4'h1;
					if (curScaled > highThr)
						startState <= motor_prot_pkg::START_ACTIVE;
					else if (curScaled >= lowThr)
						startState <= motor_prot_pkg::START_RISING;
				end
				motor_prot_pkg::START_RISING: begin
					winCount <= winCount + 4'h1;
					if (curScaled > highThr
							&& winCount < 4'(motor_prot_pkg::START_WIN_TICKS))
						startState <= motor_prot_pkg::START_ACTIVE;
					else if (curScaled < lowThr)
						startState <= motor_prot_pkg::START_STANDSTILL;
					else if (winCount >= 4'(motor_prot_pkg::START_WIN_TICKS))
						startState <= motor_prot_pkg::START_IDLE;
				end
				motor_prot_pkg::START_ACTIVE: begin
					if (curScaled < endThr)
						startState <= motor_prot_pkg::START_IDLE;
				end
				default: startState <= motor_prot_pkg::START_IDLE;
			endcase
		end
	end

	// Reset actions: keep-data group and erase group
	assign resetErase = (btnStep && btnProgram) || remoteErase || extResetIn;
	assign resetLatch = (btnProgram && !btnStep) || remoteKeep || resetErase;

	// Stall supervision
	assign stallStart = maxCurrent > stallCur;

	stage_timer #(.W(TW)) stallTimer (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.tick    (measTick),
		.run     (stallStart && !switches[motor_prot_pkg::SW_STALL_MODE]),
		.hold    (speedSwitchIn),
		.limit   (stallTime),
		.expired (dtExpired)
	);

	assign currentSq   = {16'h0000, maxCurrent} * {16'h0000, maxCurrent};
	assign stressLimit = {16'h0000, stallCur} * {16'h0000, stallCur}
		* {32'h0000_0000, stallTime};
	assign stressActive = switches[motor_prot_pkg::SW_STRESS_START] ? stallStart
		: startingSituation;
	assign stressSum  = {1'b0, stressAcc} + {17'h00000, currentSq};
	assign stressOver = stressAcc > stressLimit;

	// Accumulator saturates rather than wrapping back below the limit
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			stressAcc <= 48'h0;
		else if (speedSwitchIn)
			stressAcc <= stressAcc;
		else if (!stressActive || !switches[motor_prot_pkg::SW_STALL_MODE])
			stressAcc <= 48'h0;
		else if (measTick)
			stressAcc <= stressSum[48] ? 48'hffff_ffff_ffff : stressSum[47:0];
	end

	assign stallRaw = switches[motor_prot_pkg::SW_STALL_MODE] ? stressOver : dtExpired;
	assign stallTrip = stallRaw || stallLatch;

	// Latches: a new trip wins over a reset in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stallLatch <= 1'b0;
			hsLatch    <= 1'b0;
		end else begin
			if (stallRaw && switches[motor_prot_pkg::SW_LATCH_B])
				stallLatch <= 1'b1;
			else if (resetLatch)
				stallLatch <= 1'b0;
			if (hsRaw && (switches[motor_prot_pkg::SW_LATCH_A]
					|| switches[motor_prot_pkg::SW_LATCH_B]))
				hsLatch <= 1'b1;
			else if (resetLatch)
				hsLatch <= 1'b0;
		end
	end

	// High-set stage
	assign hsThreshold = (switches[motor_prot_pkg::SW_HS_DOUBLE] && startingSituation)
		? {1'b0, hsCur, 1'b0} : {2'b00, hsCur};
	assign hsStart = !switches[motor_prot_pkg::SW_HS_DISABLE]
		&& {2'b00, maxCurrent} > hsThreshold;
	assign hsTrip = hsRaw || hsLatch;

	stage_timer #(.W(TW)) hsTimer (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.tick    (measTick),
		.run     (hsStart),
		.hold    (1'b0),
		.limit   (hsTime),
		.expired (hsRaw)
	);

	// Earth-fault low-set stage
	assign efStart = efCurrent > efCur;

	stage_timer #(.W(TW)) efTimer (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.tick    (measTick),
		.run     (efStart),
		.hold    (1'b0),
		.limit   (efTime),
		.expired (efRaw)
	);

	// Indications: set wins over the panel reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stallIndicator      <= 1'b0;
			highsetIndicator    <= 1'b0;
			earthFaultIndicator <= 1'b0;
			displayCode         <= motor_prot_pkg::CODE_NONE;
			stallPrev           <= 1'b0;
			efTripPrev          <= 1'b0;
		end else begin
			stallPrev  <= stallTrip;
			efTripPrev <= efRaw;
			if (stallTrip && !stallPrev)
				stallIndicator <= 1'b1;
			else if (btnReset)
				stallIndicator <= 1'b0;
			if (hsRaw)
				highsetIndicator <= 1'b1;
			else if (btnReset)
				highsetIndicator <= 1'b0;
			// Signalling-only unit keeps re-asserting while active
			if (efRaw && (!efTripPrev || !switches[motor_prot_pkg::SW_EF_ROUTE]))
				earthFaultIndicator <= 1'b1;
			else if (btnReset)
				earthFaultIndicator <= 1'b0;
			if (efRaw && !efTripPrev)
				displayCode <= motor_prot_pkg::CODE_EF;
			else if (stallTrip && !stallPrev)
				displayCode <= motor_prot_pkg::CODE_STALL;
			else if (btnReset)
				displayCode <= motor_prot_pkg::CODE_NONE;
		end
	end

	// Relay outputs
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			signalOutOne      <= 1'b0;
			signalOutTwo      <= 1'b0;
			signalOutThree    <= 1'b0;
			earthFaultTripOut <= 1'b0;
			eraseRecords      <= 1'b0;
		end else begin
			signalOutOne <= stallStart && switches[motor_prot_pkg::SW_STALL_ROUTE];
			signalOutTwo <= (stallTrip && switches[motor_prot_pkg::SW_ST_TO_TWO])
				|| (hsTrip && switches[motor_prot_pkg::SW_HS_TO_TWO])
				|| (efRaw && switches[motor_prot_pkg::SW_EF_TO_TWO]);
			signalOutThree <= hsTrip
				|| (stallTrip && switches[motor_prot_pkg::SW_ST_TO_THREE])
				|| (efRaw && switches[motor_prot_pkg::SW_EF_TO_THREE]);
			earthFaultTripOut <= efRaw && switches[motor_prot_pkg::SW_EF_ROUTE];
			eraseRecords <= resetErase;
		end
	end

	property p_initLevel;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(initDone) |-> thermalInitLevel == (($past(btnStep) && $past(btnProgram))
			? motor_prot_pkg::THERM_COLD : motor_prot_pkg::THERM_WARM);
	endproperty
	a_initLevel: assert property (p_initLevel) else $error("bad thermal preset");

	property p_hsToThree;
		@(posedge clk_sys) disable iff (sys_rst)
		hsTrip |=> signalOutThree;
	endproperty
	a_hsToThree: assert property (p_hsToThree) else $error("high-set not on out3");

	property p_startRoute;
		@(posedge clk_sys) disable iff (sys_rst)
		stallStart && switches[motor_prot_pkg::SW_STALL_ROUTE] |=> signalOutOne;
	endproperty
	a_startRoute: assert property (p_startRoute) else $error("stall start not routed");

	property p_stallInd;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(stallTrip) && !(efRaw && !efTripPrev)
			|=> stallIndicator && displayCode == motor_prot_pkg::CODE_STALL;
	endproperty
	a_stallInd: assert property (p_stallInd) else $error("stall indication missing");

	property p_efInd;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(efRaw) |=> earthFaultIndicator && displayCode == motor_prot_pkg::CODE_EF;
	endproperty
	a_efInd: assert property (p_efInd) else $error("earth-fault indication missing");

	property p_speedFreeze;
		@(posedge clk_sys) disable iff (sys_rst)
		speedSwitchIn |=> stressAcc == $past(stressAcc);
	endproperty
	a_speedFreeze: assert property (p_speedFreeze) else $error("stress grew when inhibited");

	property p_hsDisabled;
		@(posedge clk_sys) disable iff (sys_rst)
		switches[motor_prot_pkg::SW_HS_DISABLE] |-> !hsStart;
	endproperty
	a_hsDisabled: assert property (p_hsDisabled) else $error("disabled high-set started");

	property p_latchRelease;
		@(posedge clk_sys) disable iff (sys_rst)
		resetLatch && !stallRaw ##1 !stallRaw |-> !stallTrip;
	endproperty
	a_latchRelease: assert property (p_latchRelease) else $error("stall latch held");

	property p_stallHold;
		@(posedge clk_sys) disable iff (sys_rst)
		stallRaw && switches[motor_prot_pkg::SW_LATCH_B] && !resetLatch ##1 !resetLatch
			|-> stallTrip;
	endproperty
	a_stallHold: assert property (p_stallHold) else $error("stall latch lost");
endmodule
`default_nettype wire

// *** design/motor_prot_pkg.sv ***
package motor_prot_pkg;
	// Current magnitudes: LSB = 0.01 x rated current; times: LSB = one measurement tick
	localparam int unsigned CUR_W     = 16;
	localparam int unsigned TIME_W    = 16;
	localparam int unsigned TICK_MS   = 10;
	// Setting ranges
	localparam logic [15:0] STALL_CUR_MIN = 16'h0064;  // 1.0 x In
	localparam logic [15:0] STALL_CUR_MAX = 16'h03e8;  // 10 x In
	localparam logic [15:0] STALL_TIM_MIN = 16'h001e;  // 0.3 s
	localparam logic [15:0] STALL_TIM_MAX = 16'h1f40;  // 80 s
	localparam logic [15:0] HS_CUR_MIN    = 16'h0032;  // 0.5 x In
	localparam logic [15:0] HS_CUR_MAX    = 16'h07d0;  // 20 x In
	localparam logic [15:0] HS_TIM_MIN    = 16'h0004;  // 0.04 s
	localparam logic [15:0] HS_TIM_MAX    = 16'h0bb8;  // 30 s
	localparam logic [15:0] EF_CUR_MIN    = 16'h0001;  // 1.0 % In
	localparam logic [15:0] EF_CUR_MAX    = 16'h0064;  // 100 % In
	localparam logic [15:0] EF_TIM_MIN    = 16'h0005;  // 0.05 s
	localparam logic [15:0] EF_TIM_MAX    = 16'h0bb8;  // 30 s
	localparam logic [15:0] FLC_RESET     = 16'h0064;
	// Thermal replica presets, percent of full capacity
	localparam logic [6:0]  THERM_WARM    = 7'h46;     // 70 %
	localparam logic [6:0]  THERM_COLD    = 7'h00;     // 0 %
	// Starting situation: thresholds in hundredths of FLC, window in ms
	localparam int unsigned START_LOW_PCT  = 12;
	localparam int unsigned START_HIGH_PCT = 150;
	localparam int unsigned START_END_PCT  = 125;
	localparam int unsigned START_WIN_MS   = 60;
	localparam int unsigned START_WIN_TICKS = START_WIN_MS / TICK_MS;
	// Display codes
	localparam logic [3:0]  CODE_NONE  = 4'h0;
	localparam logic [3:0]  CODE_STALL = 4'h6;
	localparam logic [3:0]  CODE_EF    = 4'h7;
	// Register byte offsets
	localparam logic [5:0]  OFS_SWITCH  = 6'h00;
	localparam logic [5:0]  OFS_FLC     = 6'h04;
	localparam logic [5:0]  OFS_STCUR   = 6'h08;
	localparam logic [5:0]  OFS_STTIM   = 6'h0c;
	localparam logic [5:0]  OFS_HSCUR   = 6'h10;
	localparam logic [5:0]  OFS_HSTIM   = 6'h14;
	localparam logic [5:0]  OFS_EFCUR   = 6'h18;
	localparam logic [5:0]  OFS_EFTIM   = 6'h1c;
	localparam logic [5:0]  OFS_STATUS  = 6'h20;
	localparam logic [5:0]  OFS_REMOTE  = 6'h24;
	localparam logic [5:0]  OFS_MAXCUR  = 6'h28;
	// Switch register fields
	localparam int unsigned SW_STALL_MODE   = 0;
	localparam int unsigned SW_STALL_ROUTE  = 1;
	localparam int unsigned SW_STRESS_START = 2;
	localparam int unsigned SW_LATCH_A      = 3;
	localparam int unsigned SW_LATCH_B      = 4;
	localparam int unsigned SW_HS_DOUBLE    = 5;
	localparam int unsigned SW_HS_DISABLE   = 6;
	localparam int unsigned SW_EF_ROUTE     = 7;
	localparam int unsigned SW_ST_TO_TWO    = 8;
	localparam int unsigned SW_ST_TO_THREE  = 9;
	localparam int unsigned SW_HS_TO_TWO    = 10;
	localparam int unsigned SW_EF_TO_TWO    = 11;
	localparam int unsigned SW_EF_TO_THREE  = 12;
	localparam int unsigned SW_W            = 13;
	localparam logic [12:0] SWITCH_RESET    = 13'h0080;
	localparam int unsigned RC_KEEP  = 0;
	localparam int unsigned RC_ERASE = 1;
	typedef enum logic [1:0] {
		START_IDLE      = 2'b00,
		START_STANDSTILL = 2'b01,
		START_RISING    = 2'b10,
		START_ACTIVE    = 2'b11
	} start_state_t;
endpackage

// *** design/stage_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
// Definite-time operate timer advanced once per measurement tick
module stage_timer #(
	parameter int unsigned W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic         hold,
	input  wire logic [W-1:0] limit,
	output logic              expired
);
	logic [W-1:0] count;

	if (W < 8 || W > 32) begin : gWidthCheck
		$error("stage_timer: W out of range");
	end

	// Count freezes at the limit so it cannot wrap under a long fault
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !run)
			count <= '0;
		else if (tick && !hold && count < limit)
			count <= count + W'(1);
	end

	assign expired = run && (count >= limit);
endmodule
`default_nettype wire

// *** verif/ct_front_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module ct_front_end #(
	parameter int unsigned TICK = 5
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [15:0] level,
	input  wire logic [15:0] neutralLevel,
	output logic             measTick,
	output logic [15:0]      phaseA,
	output logic [15:0]      phaseB,
	output logic [15:0]      phaseC,
	output logic [15:0]      neutral
);
	logic [7:0] cnt;
	always_ff @(posedge clk_sys) begin
		if (sys_rst || cnt == 8'(TICK - 1))
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end
	always_ff @(posedge clk_sys) measTick <= !sys_rst && cnt == 8'(TICK - 1);
	// Peak on A (C ties it while level[15:8] is zero), so a max-of-three slip to B shows up
	always_ff @(posedge clk_sys) begin
		phaseA  <= level;
		phaseB  <= level >> 1;
		phaseC  <= level - {8'h00, level[15:8]};
		neutral <= neutralLevel;
	end
endmodule
`default_nettype wire

// *** verif/motor_overcurrent_stall_stages_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module motor_overcurrent_stall_stages_test;
	localparam int TK = 5;
	logic clk_sys, sys_rst, rd, wr, waitReq, tick, btnStep, btnProgram, btnReset, spd, o1, o2, o3;
	logic extRst, erase, efTrip;
	logic [5:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] level, nLevel, pa, pb, pc, pn;
	logic [37:0] expQ[$];
	logic [37:0] expNote;
	int errorCnt, numChecks, seed;
	ct_front_end #(.TICK(TK)) i_ct_front_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.level(level), .neutralLevel(nLevel), .measTick(tick), .phaseA(pa), .phaseB(pb),
		.phaseC(pc), .neutral(pn));
	motor_overcurrent_stall_stages i_motor_overcurrent_stall_stages (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitReq),
		.measTick(tick), .phaseCurrentA(pa), .phaseCurrentB(pb), .phaseCurrentC(pc),
		.neutralCurrent(pn), .btnStep(btnStep), .btnProgram(btnProgram),
		.btnReset(btnReset), .extResetIn(extRst), .speedSwitchIn(spd),
		.signalOutOne(o1), .signalOutTwo(o2), .signalOutThree(o3),
		.earthFaultTripOut(efTrip), .stallIndicator(), .highsetIndicator(),
		.earthFaultIndicator(), .displayCode(), .eraseRecords(erase), .thermalInitLevel());
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task giveVerdict;
		$display("Checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Holds the request until waitrequest is seen low at an edge; only the watchdog ends a hang
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= d;
		if (!w)
			expQ.push_back({a, d});
		do begin
			@(posedge clk_sys);
		end while (waitReq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task ticks(input int n);
		repeat (n * TK) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (rd && waitReq === 1'b0 && expQ.size() > 0) begin
			expNote = expQ.pop_front();
			chk($sformatf("reg %h", expNote[37:32]), rdata, expNote[31:0]);
		end
	end
	initial begin
		#200000;
		errorCnt++;
		giveVerdict;
	end
	initial begin
		{sys_rst, rd, wr, btnStep, btnProgram, btnReset, spd, extRst} = 8'b10000000;
		{addr, wdata, level, nLevel} = '0;
		seed = 70;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, motor_prot_pkg::OFS_SWITCH, 32'h00000080);
		bus(1'b0, motor_prot_pkg::OFS_FLC, 32'h00000064);
		bus(1'b0, 6'h3c, 32'h00000000);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00460000);
		bus(1'b1, motor_prot_pkg::OFS_STCUR, 32'h00000005);
		bus(1'b0, motor_prot_pkg::OFS_STCUR, 32'h00000064);
		bus(1'b1, motor_prot_pkg::OFS_STTIM, 32'h0000ffff);
		bus(1'b0, motor_prot_pkg::OFS_STTIM, 32'h00001f40);
		bus(1'b1, motor_prot_pkg::OFS_STTIM, 32'h0000001e);
		bus(1'b1, motor_prot_pkg::OFS_HSCUR, 32'h000007d0);
		bus(1'b1, motor_prot_pkg::OFS_SWITCH, 32'h00000290);
		bus(1'b0, motor_prot_pkg::OFS_SWITCH, 32'h00000290);
		spd   <= 1'b1;
		level <= 16'h00c8 + (16'($random(seed)) & 16'h007f);
		ticks(40);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00460041);
		spd <= 1'b0;
		ticks(40);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h004660c3);
		chk("signalOutThree", {31'h0, o3}, 32'h1);
		level <= 16'h0000;
		ticks(3);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00466082);
		btnProgram <= 1'b1;
		ticks(1);
		chk("eraseRecords", {31'h0, erase}, 32'h0);
		btnProgram <= 1'b0;
		ticks(1);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00466080);
		btnReset <= 1'b1;
		ticks(1);
		btnReset <= 1'b0;
		ticks(1);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00460000);
		// Earth fault, unlatched high-set and stall start together, routed to all outputs
		bus(1'b1, motor_prot_pkg::OFS_HSCUR, 32'h00000032);
		bus(1'b1, motor_prot_pkg::OFS_SWITCH, 32'h00000482);
		level  <= 16'h00c8 + (16'($random(seed)) & 16'h007f);
		nLevel <= 16'h0010;
		ticks(10);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h0046737d);
		chk("signalOutOne", {31'h0, o1}, 32'h1);
		chk("signalOutTwo", {31'h0, o2}, 32'h1);
		chk("signalOutThree", {31'h0, o3}, 32'h1);
		chk("earthFaultTripOut", {31'h0, efTrip}, 32'h1);
		// Signalling only: indicator comes back through the panel reset
		bus(1'b1, motor_prot_pkg::OFS_SWITCH, 32'h00000402);
		btnReset <= 1'b1;
		ticks(1);
		btnReset <= 1'b0;
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h0046037d);
		chk("earthFaultTripOut", {31'h0, efTrip}, 32'h0);
		extRst <= 1'b1;
		@(posedge clk_sys);
		extRst <= 1'b0;
		@(negedge clk_sys);
		chk("eraseRecords", {31'h0, erase}, 32'h1);
		@(posedge clk_sys);
		// Stress mode: nothing builds up while the speed switch is active
		spd <= 1'b1;
		bus(1'b1, motor_prot_pkg::OFS_SWITCH, 32'h00000045);
		ticks(10);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h00460371);
		spd <= 1'b0;
		ticks(10);
		bus(1'b0, motor_prot_pkg::OFS_STATUS, 32'h004663f3);
		giveVerdict;
	end
endmodule
`default_nettype wire
